//--- slfc_pkg.sv
// Constants shared by the serial link flow-control block.
// Assumes a 32-bit APB register bus and one clock domain.
`default_nettype none

package slfc_pkg;

	// ==============================================================
	// Register byte offsets
	localparam logic [7:0] SLFC_REG_CTRL  = 8'h00;
	localparam logic [7:0] SLFC_REG_CODES = 8'h04;
	localparam logic [7:0] SLFC_REG_STAT  = 8'h08;
	localparam logic [7:0] SLFC_REG_CMD   = 8'h0C;

	// ==============================================================
	// Control field positions
	localparam int SLFC_CTRL_METH   = 0;   // Two bits: flow-control method
	localparam int SLFC_CTRL_DC13TX = 2;
	localparam int SLFC_CTRL_DC13RX = 3;
	localparam int SLFC_CTRL_DC24RX = 4;
	localparam int SLFC_CTRL_FDX    = 5;   // Full duplex link
	localparam int SLFC_CTRL_MODE   = 8;   // Four bits: mode number
	localparam int SLFC_CTRL_W      = 12;

	// Command bits (write one)
	localparam int SLFC_CMD_CLEAR  = 0;
	localparam int SLFC_CMD_ERRCLR = 1;

	// Status field positions
	localparam int SLFC_ST_FREE  = 0;   // Eight bits of free space
	localparam int SLFC_ST_DTR   = 8;
	localparam int SLFC_ST_OK    = 9;
	localparam int SLFC_ST_DC3   = 10;
	localparam int SLFC_ST_SUSP  = 11;
	localparam int SLFC_ST_ERR   = 12;
	localparam int SLFC_ST_FRAME = 13;

	// ==============================================================
	// Method, modes, codes, thresholds
	typedef enum logic [1:0] {
		SLFC_M_NONE = 2'h0,
		SLFC_M_HW   = 2'h1,
		SLFC_M_DC   = 2'h3
	} slfc_method_e;

	localparam logic [3:0]  SLFC_MODE_NOPROTO = 4'h9;
	localparam logic [11:0] SLFC_CTRL_RESET   = 12'h921;   // Mode 9, duplex, handshake
	localparam logic [31:0] SLFC_CODES_RESET  = 32'h1413_1211; // DC4..DC1
	localparam int          SLFC_FREE_LO      = 10;
	localparam int          SLFC_FREE_HI      = 41;
	localparam logic        SLFC_PORT_232     = 1'b0;
	localparam logic        SLFC_PORT_422     = 1'b1;

endpackage : slfc_pkg

`default_nettype wire

//--- slfc_sync.sv
// Two-flop synchroniser for levels arriving from pins.
// Assumes the input is a slowly changing level.
`default_nettype none

module slfc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	// Level in and out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// Only the second stage reads the first
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : slfc_sync

`default_nettype wire

//--- slfc_stage.sv
// Receive staging area: byte FIFO with registered output and free count.
// Assumes a single clock; the drain side may stall at will.
`default_nettype none

module slfc_stage #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	// Fill side
	input  wire logic         wr_en,
	input  wire logic [7:0]   wr_data,
	// Drain side
	output logic              out_valid,
	output logic [7:0]        out_data,
	input  wire logic         out_ready,
	// Control and state
	input  wire logic         flush,
	output logic [AW:0]       free
);

	logic [7:0]  mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          pop, take, do_wr;

	// Output register refills when empty or when taken
	assign take  = !out_valid || out_ready;
	assign pop   = take && (cnt_q != '0);
	// The head byte still occupies the area, so it counts against free space
	assign do_wr = wr_en && (free != '0);
	assign free  = (AW+1)'(DEPTH) - cnt_q - (AW+1)'(out_valid);

	// Storage array
	always_ff @(posedge mclk) begin
		if (clk_en && do_wr) begin
			mem[wp_q] <= wr_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wp_q  <= '0;
				rp_q  <= '0;
				cnt_q <= '0;
			end else begin
				if (do_wr) wp_q <= wp_q + 1'b1;
				if (pop) rp_q <= rp_q + 1'b1;
				cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(pop);
			end
		end
	end

	// Registered head byte
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (clk_en) begin
			if (flush) begin
				out_valid <= 1'b0;
			end else if (take) begin
				out_valid <= pop;
				if (pop) out_data <= mem[rp_q];
			end
		end
	end

endmodule : slfc_stage

`default_nettype wire

//--- slfc_top.sv
// Flow-control block of a two-port serial link: handshake line control,
// in-band control characters and the receive staging area, behind APB.
// Assumes receiver, transmitter and buffer memory run on mclk.
`default_nettype none

module slfc_top
	import slfc_pkg::*;
#(
	parameter int STAGE_DEPTH = 64,
	parameter int STAGE_AW    = 6
) (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Received bytes from the line receivers
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_port,
	// Staging area drain to buffer memory
	input  wire logic        read_request_flag,
	output logic             buf_valid,
	output logic [7:0]       buf_data,
	input  wire logic        buf_ready,
	// Send data from the CPU side
	input  wire logic        tx_in_valid,
	input  wire logic [7:0]  tx_in_data,
	input  wire logic        tx_in_port,
	output logic             tx_in_ready,
	// Bytes to the line transmitters
	output logic             tx_out_valid,
	output logic [7:0]       tx_out_data,
	output logic             tx_out_port,
	output logic             tx_out_both,
	input  wire logic        tx_out_ready,
	// Line pins and indicator
	input  wire logic        set_ready_pin,
	output logic             terminal_ready,
	output logic             serial_error_indicator
);

	// ==============================================================
	// Declarations
	logic [SLFC_CTRL_W-1:0] ctrl_q;
	logic [31:0]            codes_q;
	logic                   apb_acc, apb_wr, mode_chg;
	logic                   clr_pulse, errclr_pulse;
	logic [31:0]            rd_mux;
	logic                   rd_hit;
	slfc_method_e           meth;
	logic                   noproto, fdx, hw, dcm;
	logic                   dc13_tx, dc13_rx, dc24_rx;
	logic                   set_ready_s;
	logic [STAGE_AW:0]      free;
	logic                   space_ok_q, dc3_sent_q, susp_q, frame_q, discard_q;
	logic                   rx_take, rx_ctl, rx_store, rx_full;
	logic                   hold_v_q, hold_v_d, hold_port_q;
	logic [7:0]             hold_data_q;
	logic                   need_dc3, need_dc1, out_free, may_send, load_hold;

	// Compare a received byte with one code field
	function automatic logic code_is(input logic [7:0] b, input logic [31:0] codes,
		input int idx);
		code_is = (b == codes[idx*8 +: 8]);
	endfunction : code_is

	// ==============================================================
	// Mode decode
	assign meth    = slfc_method_e'(ctrl_q[SLFC_CTRL_METH +: 2]);
	assign noproto = (ctrl_q[SLFC_CTRL_MODE +: 4] == SLFC_MODE_NOPROTO);
	assign fdx     = ctrl_q[SLFC_CTRL_FDX];
	assign hw      = (meth == SLFC_M_HW);
	assign dcm     = (meth == SLFC_M_DC);
	assign dc13_tx = dcm && ctrl_q[SLFC_CTRL_DC13TX] && noproto && fdx;
	assign dc13_rx = dcm && ctrl_q[SLFC_CTRL_DC13RX] && fdx;
	assign dc24_rx = dcm && ctrl_q[SLFC_CTRL_DC24RX];

	// ==============================================================
	// APB slave, one wait state
	assign apb_acc = psel && penable && pready;
	assign apb_wr  = apb_acc && pwrite;
	assign mode_chg = apb_wr && (paddr == SLFC_REG_CTRL) &&
		(pwdata[SLFC_CTRL_MODE +: 4] != ctrl_q[SLFC_CTRL_MODE +: 4]);
	assign clr_pulse    = apb_wr && (paddr == SLFC_REG_CMD) && pwdata[SLFC_CMD_CLEAR];
	assign errclr_pulse = apb_wr && (paddr == SLFC_REG_CMD) && pwdata[SLFC_CMD_ERRCLR];

	// Read data selection
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (paddr)
			SLFC_REG_CTRL:  rd_mux = {{(32-SLFC_CTRL_W){1'b0}}, ctrl_q};
			SLFC_REG_CODES: rd_mux = codes_q;
			SLFC_REG_STAT: begin
				rd_mux[SLFC_ST_FREE +: 8] = 8'(free);
				rd_mux[SLFC_ST_DTR]       = terminal_ready;
				rd_mux[SLFC_ST_OK]        = space_ok_q;
				rd_mux[SLFC_ST_DC3]       = dc3_sent_q;
				rd_mux[SLFC_ST_SUSP]      = susp_q;
				rd_mux[SLFC_ST_ERR]       = serial_error_indicator;
				rd_mux[SLFC_ST_FRAME]     = frame_q;
			end
			SLFC_REG_CMD:   rd_mux = '0;
			default:        rd_hit = 1'b0;
		endcase
	end

	// Bus handshake and read data
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (clk_en) begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				pslverr <= !rd_hit;
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q  <= SLFC_CTRL_RESET;
			codes_q <= SLFC_CODES_RESET;
		end else if (clk_en && apb_wr) begin
			if (paddr == SLFC_REG_CTRL) ctrl_q <= pwdata[SLFC_CTRL_W-1:0];
			if (paddr == SLFC_REG_CODES) codes_q <= pwdata;
		end
	end

	// ==============================================================
	// Set-ready pin synchroniser
	slfc_sync #(
		.W        (1)
	) u_sync (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (set_ready_pin),
		.sync_out (set_ready_s)
	);

	// ==============================================================
	// Receive path
	assign rx_take = rx_valid && !(hw && rx_port == SLFC_PORT_422);
	assign rx_ctl  = (dc13_rx && (code_is(rx_data, codes_q, 0) ||
		code_is(rx_data, codes_q, 2))) || (dc24_rx &&
		(code_is(rx_data, codes_q, 1) || code_is(rx_data, codes_q, 3)));
	assign rx_store = rx_take && !rx_ctl && (!dc24_rx || frame_q);
	assign rx_full  = (free == '0);

	// Staging area; drained only while read request is low
	slfc_stage #(
		.DEPTH     (STAGE_DEPTH),
		.AW        (STAGE_AW)
	) u_stage (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.wr_en     (rx_store && !discard_q),
		.wr_data   (rx_data),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (buf_ready && !read_request_flag),
		.flush     (clr_pulse),
		.free      (free)
	);

	// Overflow discard window and sticky error, set wins over clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			discard_q              <= 1'b0;
			serial_error_indicator <= 1'b0;
		end else if (clk_en) begin
			if (rx_store && rx_full) begin
				discard_q              <= 1'b1;
				serial_error_indicator <= 1'b1;
			end else begin
				if (clr_pulse || free > (STAGE_AW+1)'(SLFC_FREE_HI)) discard_q <= 1'b0;
				if (errclr_pulse) serial_error_indicator <= 1'b0;
			end
		end
	end

	// Suspend by DC3, resume by DC1; DC2/DC4 frame the valid data
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			susp_q  <= 1'b0;
			frame_q <= 1'b0;
		end else if (clk_en) begin
			if (mode_chg || !dc13_rx) begin
				susp_q <= 1'b0;
			end else if (rx_take && code_is(rx_data, codes_q, 2)) begin
				susp_q <= 1'b1;
			end else if (rx_take && code_is(rx_data, codes_q, 0)) begin
				susp_q <= 1'b0;
			end
			if (!dc24_rx) begin
				frame_q <= 1'b0;
			end else if (rx_take && code_is(rx_data, codes_q, 1)) begin
				frame_q <= 1'b1;
			end else if (rx_take && code_is(rx_data, codes_q, 3)) begin
				frame_q <= 1'b0;
			end
		end
	end

	// ==============================================================
	// Free-space hysteresis and terminal-ready
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			space_ok_q     <= 1'b1;
			terminal_ready <= 1'b1;
		end else if (clk_en) begin
			if (free < (STAGE_AW+1)'(SLFC_FREE_LO)) begin
				space_ok_q <= 1'b0;
			end else if (free > (STAGE_AW+1)'(SLFC_FREE_HI)) begin
				space_ok_q <= 1'b1;
			end
			if (hw && noproto) begin
				terminal_ready <= (free < (STAGE_AW+1)'(SLFC_FREE_LO)) ? 1'b0 :
					(free > (STAGE_AW+1)'(SLFC_FREE_HI)) ? 1'b1 : terminal_ready;
			end else begin
				terminal_ready <= 1'b1;
			end
		end
	end

	// ==============================================================
	// Transmit path
	assign need_dc3  = dc13_tx && !space_ok_q && !dc3_sent_q;
	assign need_dc1  = dc13_tx && space_ok_q && dc3_sent_q;
	assign out_free  = !tx_out_valid || tx_out_ready;
	assign may_send  = (!hw || set_ready_s) && !susp_q;
	assign load_hold = out_free && !need_dc3 && !need_dc1 && hold_v_q &&
		(may_send || (hw && hold_port_q == SLFC_PORT_422));

	// Holding slot for one CPU byte
	always_comb begin
		hold_v_d = hold_v_q;
		if (load_hold) hold_v_d = 1'b0;
		if (tx_in_valid && tx_in_ready) hold_v_d = 1'b1;
	end

	// Holding slot registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold_v_q    <= 1'b0;
			hold_data_q <= '0;
			hold_port_q <= SLFC_PORT_232;
			tx_in_ready <= 1'b0;
		end else if (clk_en) begin
			hold_v_q    <= hold_v_d;
			tx_in_ready <= !hold_v_d;
			if (tx_in_valid && tx_in_ready) begin
				hold_data_q <= tx_in_data;
				hold_port_q <= tx_in_port;
			end
		end
	end

	// Output byte: flow characters first, then CPU data
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_out_valid <= 1'b0;
			tx_out_data  <= '0;
			tx_out_port  <= SLFC_PORT_232;
			tx_out_both  <= 1'b0;
			dc3_sent_q   <= 1'b0;
		end else if (clk_en) begin
			if (mode_chg) dc3_sent_q <= 1'b0;
			if (out_free) begin
				tx_out_valid <= 1'b0;
				if (need_dc3 || need_dc1) begin
					tx_out_valid <= 1'b1;
					tx_out_data  <= need_dc3 ? codes_q[23:16] : codes_q[7:0];
					tx_out_both  <= 1'b1;
					if (!mode_chg) dc3_sent_q <= need_dc3;
				end else if (load_hold) begin
					tx_out_valid <= !(hw && hold_port_q == SLFC_PORT_422);
					tx_out_data  <= hold_data_q;
					tx_out_port  <= hold_port_q;
					tx_out_both  <= 1'b0;
				end
			end
		end
	end

endmodule : slfc_top

`default_nettype wire

//--- slfc_top_assertions.sv
// Checker for the flow-control block, bound to slfc_top.
// Assumes clk_en stays high and APB writes are whole words.
`default_nettype none

module slfc_top_assertions
	import slfc_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Staging drain and transmit side
	input wire logic        read_request_flag,
	input wire logic        buf_valid,
	input wire logic [7:0]  buf_data,
	input wire logic        buf_ready,
	input wire logic        tx_out_valid,
	input wire logic        tx_out_port,
	input wire logic        tx_out_both,
	// Pins
	input wire logic        set_ready_pin,
	input wire logic        terminal_ready,
	input wire logic        serial_error_indicator
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// ==============================================================
	// Shadow of the method field and command writes
	logic       ctrl_w;
	logic       cmd_w;
	logic [1:0] meth_q;
	assign ctrl_w = psel && penable && pready && pwrite && (paddr == SLFC_REG_CTRL);
	assign cmd_w  = psel && penable && pready && pwrite && (paddr == SLFC_REG_CMD);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meth_q <= SLFC_M_HW;
		end else if (ctrl_w) begin
			meth_q <= pwdata[1:0];
		end
	end

	// ==============================================================
	// Properties
	sequence acc_start;
		psel && penable && !pready;
	endsequence
	sequence dsr_low_idle;
		(meth_q == SLFC_M_HW && !set_ready_pin)[*5] ##0 !tx_out_valid;
	endsequence

	chk_apb_one_wait: assert property (acc_start |=> pready)
		else $error("APB answer not after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside an access");
	chk_tr_no_hw: assert property ((meth_q != SLFC_M_HW)[*2] |-> terminal_ready)
		else $error("terminal ready low without handshake");
	chk_hw_no_alt: assert property (tx_out_valid && !tx_out_both && meth_q == SLFC_M_HW
		|-> tx_out_port == SLFC_PORT_232)
		else $error("second port sends under handshake");
	chk_dsr_holds_tx: assert property (dsr_low_idle |=> !tx_out_valid)
		else $error("byte sent while set ready low");
	chk_err_sticky: assert property (serial_error_indicator && !cmd_w && !$past(cmd_w)
		|=> serial_error_indicator)
		else $error("error indicator dropped by itself");
	chk_buf_hold: assert property (buf_valid && !(buf_ready && !read_request_flag) && !cmd_w
		&& !$past(cmd_w) |=> buf_valid && $stable(buf_data))
		else $error("staged byte lost before taken");
endmodule : slfc_top_assertions

bind slfc_top slfc_top_assertions chk (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .read_request_flag, .buf_valid, .buf_data, .buf_ready,
	.tx_out_valid, .tx_out_port, .tx_out_both, .set_ready_pin, .terminal_ready,
	.serial_error_indicator);

`default_nettype wire

//--- slfc_line_model.sv
// Far-side terminal: takes sent bytes and drives the set-ready line.
// Assumes one clock shared with the block.
`default_nettype none

module slfc_line_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Bytes from the block
	input  wire logic       tx_out_valid,
	input  wire logic [7:0] tx_out_data,
	output var  logic       tx_out_ready,
	// Terminal state
	input  wire logic       dsr_on,
	input  wire logic       slow,
	output logic            set_ready_pin,
	output var  logic [7:0] last_byte,
	output var  int         seen
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==============================================================
	// Receiver of the terminal, stalls every other cycle when slow
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_out_ready <= 1'b0;
			seen         <= 0;
			last_byte    <= 8'h00;
		end else begin
			tx_out_ready <= slow ? ~tx_out_ready : 1'b1;
			if (tx_out_valid && tx_out_ready) begin
				seen      <= seen + 1;
				last_byte <= tx_out_data;
			end
		end
	end

	// Ready level of the terminal
	assign set_ready_pin = dsr_on;
endmodule : slfc_line_model

`default_nettype wire

//--- slfc_top_tb.sv
// Self-checking bench for slfc_top over APB and the byte ports.
// Assumes the package defaults and a 64-byte staging area.
`default_nettype none

module slfc_top_tb;
	import slfc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
	logic        rx_valid, rx_port, read_request_flag, buf_valid, buf_ready;
	logic        tx_in_valid, tx_in_port, tx_in_ready, tx_out_valid, tx_out_port;
	logic        tx_out_both, tx_out_ready, set_ready_pin, dsr_on, slow;
	logic        terminal_ready, serial_error_indicator;
	logic [7:0]  paddr, rx_data, buf_data, tx_in_data, tx_out_data, last_byte;
	logic [31:0] pwdata, prdata, rd;
	int          seen, s, miscompares, cmp_count;

	slfc_top uut (.mclk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_port, .read_request_flag,
		.buf_valid, .buf_data, .buf_ready, .tx_in_valid, .tx_in_data, .tx_in_port,
		.tx_in_ready, .tx_out_valid, .tx_out_data, .tx_out_port, .tx_out_both,
		.tx_out_ready, .set_ready_pin, .terminal_ready, .serial_error_indicator);
	slfc_line_model line (.mclk, .reset_n, .tx_out_valid, .tx_out_data, .tx_out_ready,
		.dsr_on, .slow, .set_ready_pin, .last_byte, .seen);

	// ==============================================================
	// Clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		test_done;
	end

	// ==============================================================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task push(input int n, input logic [7:0] b);
		@(posedge mclk);
		rx_data <= b;
		rx_valid <= 1'b1;
		repeat (n) @(posedge mclk);
		rx_valid <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : push
	task drain(input int n);
		int k;
		int j;
		k = 0;
		j = 0;
		@(posedge mclk);
		read_request_flag <= 1'b0;
		while (k < n && j < 2000) begin
			@(posedge mclk);
			j++;
			if (buf_valid === 1'b1) begin
				k++;
				chk(buf_data, 8'h41);
			end
		end
		chk(k, n);
		read_request_flag <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask : drain
	task send(input logic [7:0] b, input logic p);
		int j;
		j = 0;
		@(posedge mclk);
		tx_in_data <= b;
		tx_in_port <= p;
		tx_in_valid <= 1'b1;
		do begin
			@(posedge mclk);
			j++;
		end while (tx_in_ready !== 1'b1 && j < 100);
		if (j >= 100) miscompares++;
		tx_in_valid <= 1'b0;
	endtask : send
	task wseen(input int n);
		for (int j = 0; j < 200 && seen != n; j++) @(posedge mclk);
		chk(seen, n);
	endtask : wseen
	task free_is(input int n);
		apb(1'b0, SLFC_REG_STAT, 32'h0);
		chk(rd[7:0], n);
	endtask : free_is
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// ==============================================================
	// Test sequence
	initial begin
		{psel, penable, pwrite, rx_valid, rx_port, tx_in_valid, tx_in_port, slow} = '0;
		{paddr, rx_data, tx_in_data, pwdata} = '0;
		{clk_en, read_request_flag, buf_ready, dsr_on} = 4'hF;
		miscompares = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, SLFC_REG_CTRL, 32'h0);
		chk(rd, {20'h0, SLFC_CTRL_RESET});
		apb(1'b0, SLFC_REG_CODES, 32'h0);
		chk(rd, SLFC_CODES_RESET);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk(err, 1'b1);
		$display("test registers finished");
		rx_port <= 1'b1;
		push(3, 8'h41);
		free_is(64);
		rx_port <= 1'b0;
		push(54, 8'h41);
		free_is(10);
		chk(terminal_ready, 1'b1);
		push(1, 8'h41);
		chk(terminal_ready, 1'b0);
		drain(32);
		free_is(41);
		chk(terminal_ready, 1'b0);
		drain(1);
		chk(terminal_ready, 1'b1);
		push(43, 8'h41);
		chk(serial_error_indicator, 1'b1);
		drain(1);
		push(1, 8'h41);
		free_is(1);
		apb(1'b1, SLFC_REG_CMD, 32'h1);
		free_is(64);
		chk(serial_error_indicator, 1'b1);
		apb(1'b1, SLFC_REG_CMD, 32'h2);
		repeat (2) @(posedge mclk);
		chk(serial_error_indicator, 1'b0);
		$display("test staging finished");
		s = seen;
		dsr_on <= 1'b0;
		send(8'h13, 1'b0);
		repeat (20) @(posedge mclk);
		chk(seen, s);
		dsr_on <= 1'b1;
		wseen(s + 1);
		chk(last_byte, 8'h13);
		send(8'h41, 1'b1);
		repeat (20) @(posedge mclk);
		chk(seen, s + 1);
		push(55, 8'h41);
		apb(1'b1, SLFC_REG_CTRL, 32'h920);
		repeat (2) @(posedge mclk);
		chk(terminal_ready, 1'b1);
		dsr_on <= 1'b0;
		send(8'h55, 1'b0);
		wseen(s + 2);
		dsr_on <= 1'b1;
		apb(1'b1, SLFC_REG_CMD, 32'h1);
		$display("test handshake finished");
		apb(1'b1, SLFC_REG_CTRL, 32'h92F);
		slow <= 1'b1;
		repeat (10) @(posedge mclk);
		chk(seen, s + 2);
		push(55, 8'h41);
		wseen(s + 3);
		chk(last_byte, SLFC_CODES_RESET[23:16]);
		chk(terminal_ready, 1'b1);
		chk(tx_out_both, 1'b1);
		drain(33);
		wseen(s + 4);
		chk(last_byte, SLFC_CODES_RESET[7:0]);
		push(1, 8'h13);
		apb(1'b0, SLFC_REG_STAT, 32'h0);
		chk(rd[SLFC_ST_SUSP], 1'b1);
		chk(rd[7:0], 42);
		send(8'h41, 1'b0);
		repeat (20) @(posedge mclk);
		chk(seen, s + 4);
		push(1, 8'h11);
		wseen(s + 5);
		chk(tx_out_both, 1'b0);
		free_is(42);
		apb(1'b1, SLFC_REG_CTRL, 32'h93F);
		push(2, 8'h41);
		push(1, 8'h12);
		push(2, 8'h41);
		push(1, 8'h14);
		push(1, 8'h41);
		free_is(40);
		chk(rd[SLFC_ST_FRAME], 1'b0);
		push(1, 8'h13);
		apb(1'b1, SLFC_REG_CTRL, 32'hA2F);
		free_is(40);
		chk(rd[SLFC_ST_SUSP], 1'b0);
		$display("test control characters finished");
		test_done;
	end
endmodule : slfc_top_tb

`default_nettype wire
